// file: src/gfr_dev.sv
// gauge device end: resets, default mode, fault latching, zero-return pin
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module gfr_dev
  import gfr_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  gfr_link_if.dev                  link,
  input  wire logic                vdd_ok,
  input  wire logic                motor_supply_below_min,
  input  wire logic                motor_supply_uv,
  input  wire logic                motor_supply_ov,
  input  wire logic [1:0]          overtemp,
  input  wire logic [3:0]          coil_sense,
  input  wire logic                zr_active,
  input  wire logic                zr_gauge,
  input  wire logic                zr_drive_sin,
  output logic      [1:0]          coil_en_ff,
  output logic      [1:0]          overtemp_flag_ff,
  output logic                     cal_en_ff,
  output logic                     freq_sel_ff,
  output logic      [ZR_STEP_W-1:0] full_step_time_field_ff,
  output logic                     blanking_time_bit_ff,
  output logic      [ZR_PHI_W-1:0] accumulator_preload_high_ff,
  output logic      [ZR_PLO_W-1:0] accumulator_preload_low_ff,
  output logic      [3:0]          cal_divisor_ff,
  output logic                     motion_run_ff,
  output logic                     sleep_ff,
  output logic                     zero_return_ff
);
  localparam int NS = 17;

  logic [NS-1:0]          syn;
  logic                   rst_pin_s, cs_s, sclk_s, mosi_s, vdd_s, below_s, uv_s, ov_s;
  logic [1:0]             ot_s;
  logic [3:0]             sense_s;
  logic                   zra_s, zrg_s, zrd_s;
  logic                   cs_q_ff, sclk_q_ff;
  logic                   cs_fall, cs_rise, sck_rise, sck_fall, srst;
  logic [4:0]             bit_cnt_ff;
  logic [FRAME_BITS-1:0]  rx_ff, tx_ff, snap_ff, stat;
  logic                   snap_fmt_ff, so_ff, oe_ff, fmt_ff;
  logic                   frame_ok, wr_ec, wr_zr, clr;
  logic [8:0]             pre_ff, tick_lim;
  logic [CAL_CNT_W-1:0]   ticks_ff;
  logic                   cal_done, cal_bad;
  logic                   uv_flag_ff, ov_flag_ff, cal_flag_ff;

  gfr_sync #(.W(NS), .RST_VAL(17'h18000)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({link.rst_pin_n, link.cs_n, link.sclk, link.mosi, vdd_ok, motor_supply_below_min,
                motor_supply_uv, motor_supply_ov, overtemp, coil_sense, zr_active, zr_gauge, zr_drive_sin}),
    .q_ff     (syn)
  );

  assign {rst_pin_s, cs_s, sclk_s, mosi_s, vdd_s, below_s, uv_s, ov_s, ot_s, sense_s, zra_s, zrg_s, zrd_s} = syn;

  // internal and external reset sources
  assign srst     = ~vdd_s | below_s | ~rst_pin_s;
  assign cs_fall  = cs_q_ff & ~cs_s;
  assign cs_rise  = ~cs_q_ff & cs_s;
  assign sck_rise = ~sclk_q_ff & sclk_s & ~cs_s;
  assign sck_fall = sclk_q_ff & ~sclk_s & ~cs_s;
  assign frame_ok = cs_rise & (bit_cnt_ff == 5'(FRAME_BITS)) & ~srst;
  assign wr_ec    = frame_ok & (rx_ff[CMD_LSB +: CMD_W] == CMD_ENCAL);
  assign wr_zr    = frame_ok & (rx_ff[CMD_LSB +: CMD_W] == CMD_ZRCFG);
  assign clr      = frame_ok & ~snap_fmt_ff;
  assign link.miso    = so_ff;
  assign link.miso_oe = oe_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q_ff   <= 1'b1;
      sclk_q_ff <= 1'b0;
    end else begin
      cs_q_ff   <= cs_s;
      sclk_q_ff <= sclk_s;
    end
  end

  // status word; no overcurrent bit exists
  always_comb begin
    stat = '0;
    if (!fmt_ff) begin
      stat[SO_OT0 +: 2] = overtemp_flag_ff;
      stat[SO_UV]       = uv_flag_ff;
      stat[SO_OV]       = ov_flag_ff;
      stat[SO_CAL]      = cal_flag_ff;
      stat[SO_ZR]       = zra_s;
    end else begin
      stat[ZR_STEP_LSB +: ZR_STEP_W] = full_step_time_field_ff;
      stat[ZR_BLANK]                 = blanking_time_bit_ff;
      stat[ZR_PLO_LSB +: ZR_PLO_W]   = accumulator_preload_low_ff;
      stat[ZR_PHI_LSB +: ZR_PHI_W]   = accumulator_preload_high_ff;
    end
  end

  // serial shift engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff  <= '0;
      rx_ff       <= '0;
      tx_ff       <= '0;
      snap_ff     <= '0;
      snap_fmt_ff <= 1'b0;
      so_ff       <= 1'b0;
      oe_ff       <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_ff  <= '0;
      tx_ff       <= stat;
      snap_ff     <= stat;
      snap_fmt_ff <= fmt_ff;
      so_ff       <= stat[FRAME_BITS-1];
      oe_ff       <= 1'b1;
    end else if (cs_rise) begin
      oe_ff <= 1'b0;
    end else begin
      if (sck_rise) begin
        rx_ff <= {rx_ff[FRAME_BITS-2:0], mosi_s};
        if (bit_cnt_ff != 5'h1f) begin
          bit_cnt_ff <= bit_cnt_ff + 5'h1;
        end
      end
      if (sck_fall) begin
        tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
        so_ff <= tx_ff[FRAME_BITS-2];
      end
    end
  end

  // calibration pulse timing
  assign tick_lim = freq_sel_ff ? 9'(CAL_SLOW_CYC - 1) : 9'(CAL_TICK_CYC - 1);
  assign cal_done = cs_rise & (bit_cnt_ff == 5'h0) & cal_en_ff & ~srst;
  assign cal_bad  = cal_done & ((ticks_ff < 5'(CAL_MIN)) | (ticks_ff > 5'(CAL_MAX)));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff   <= '0;
      ticks_ff <= '0;
    end else if (cs_fall) begin
      pre_ff   <= 9'h1; // fall cycle is the first low cycle
      ticks_ff <= '0;
    end else if (!cs_s) begin
      if (pre_ff == tick_lim) begin
        pre_ff <= '0;
        if (ticks_ff != '1) begin
          ticks_ff <= ticks_ff + 5'h1;
        end
      end else begin
        pre_ff <= pre_ff + 9'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_divisor_ff <= '0;
    end else if (srst) begin
      cal_divisor_ff <= '0;
    end else if (cal_done && !cal_bad) begin
      cal_divisor_ff <= ticks_ff[3:0];
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_en_ff                   <= 1'b0;
      freq_sel_ff                 <= 1'b0;
      fmt_ff                      <= 1'b0;
      full_step_time_field_ff     <= ZR_STEP_DFLT;
      blanking_time_bit_ff        <= 1'b0;
      accumulator_preload_high_ff <= '0;
      accumulator_preload_low_ff  <= '0;
    end else if (srst) begin
      cal_en_ff                   <= 1'b0;
      freq_sel_ff                 <= 1'b0;
      fmt_ff                      <= 1'b0;
      full_step_time_field_ff     <= ZR_STEP_DFLT;
      blanking_time_bit_ff        <= 1'b0;
      accumulator_preload_high_ff <= '0;
      accumulator_preload_low_ff  <= '0;
    end else if (wr_ec) begin
      cal_en_ff   <= rx_ff[EC_CAL_EN];
      freq_sel_ff <= rx_ff[EC_FREQ_SEL];
      fmt_ff      <= rx_ff[EC_FMT_SEL];
    end else if (wr_zr) begin
      full_step_time_field_ff     <= rx_ff[ZR_STEP_LSB +: ZR_STEP_W];
      blanking_time_bit_ff        <= rx_ff[ZR_BLANK];
      accumulator_preload_high_ff <= rx_ff[ZR_PHI_LSB +: ZR_PHI_W];
      accumulator_preload_low_ff  <= rx_ff[ZR_PLO_LSB +: ZR_PLO_W];
    end
  end

  // per-gauge enable and thermal flag
  for (genvar g = 0; g < 2; g++) begin : g_gauge
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        coil_en_ff[g]       <= 1'b0;
        overtemp_flag_ff[g] <= 1'b0;
      end else if (srst) begin
        coil_en_ff[g]       <= 1'b0;
        overtemp_flag_ff[g] <= 1'b0;
      end else begin
        if (ot_s[g]) begin
          coil_en_ff[g] <= 1'b0;
        end else if (wr_ec) begin
          coil_en_ff[g] <= rx_ff[EC_GAUGE0 + g];
        end
        overtemp_flag_ff[g] <= ot_s[g] | (overtemp_flag_ff[g] & ~(wr_ec & rx_ff[EC_GAUGE0 + g]));
      end
    end
  end

  // supply and clock fault latches, set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_flag_ff  <= 1'b1;
      ov_flag_ff  <= 1'b0;
      cal_flag_ff <= 1'b0;
    end else if (srst) begin
      uv_flag_ff  <= 1'b1;
      ov_flag_ff  <= 1'b0;
      cal_flag_ff <= 1'b0;
    end else begin
      uv_flag_ff  <= (uv_s & (|coil_en_ff)) | (uv_flag_ff & ~(clr & snap_ff[SO_UV]));
      ov_flag_ff  <= ov_s | (ov_flag_ff & ~(clr & snap_ff[SO_OV]));
      cal_flag_ff <= cal_bad | (cal_flag_ff & ~(clr & snap_ff[SO_CAL]));
    end
  end

  // run, sleep and zero-return pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_run_ff  <= 1'b0;
      sleep_ff       <= 1'b1;
      zero_return_ff <= 1'b0;
    end else begin
      motion_run_ff  <= ~srst;
      sleep_ff       <= ~rst_pin_s;
      zero_return_ff <= zra_s & sense_s[{zrg_s, ~zrd_s}];
    end
  end
endmodule : gfr_dev

// file: src/gfr_host.sv
// host end: avalon-mm command registers, serial master, bring-up sequencer
module gfr_host
  import gfr_pkg::*;
#(
  parameter int SCK_HALF  = 8,
  parameter int MAX_TRIES = 4
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  gfr_link_if.host               link,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata_ff,
  output logic                   avs_waitrequest_ff
);
  typedef enum logic [2:0] {HS_IDLE, HS_RESET, HS_ENC, HS_PULSE, HS_ZRC, HS_ONE} gfr_hstate_e;

  gfr_hstate_e            st_ff;
  logic [1:0]             mi_s;
  logic                   wr_acc, ctrl_wr;
  logic [31:0]            rd_mux;
  logic [FRAME_BITS-1:0]  tx_ff, rx_ff, sh_ff, go_word_ff, enc_word, zr_word;
  logic [PAY_W-1:0]       cfg_ec_ff, cfg_zr_ff;
  logic                   go_ff, go_pulse_ff, busy_ff, done_ff, pulse_ff;
  logic                   cs_ff, sclk_ff, mosi_ff, rst_pin_ff;
  logic [15:0]            cnt_ff, lim, hold_ff;
  logic [5:0]             ph_ff;
  logic [2:0]             tries_ff;
  logic                   fail_ff, ok_ff;

  gfr_sync #(.W(2), .RST_VAL(2'h0)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({link.miso_oe, link.miso}),
    .q_ff     (mi_s)
  );

  assign link.cs_n      = cs_ff;
  assign link.sclk      = sclk_ff;
  assign link.mosi      = mosi_ff;
  assign link.rst_pin_n = rst_pin_ff;
  assign wr_acc  = avs_write & ~avs_waitrequest_ff;
  assign ctrl_wr = wr_acc & (avs_address == REG_CTRL) & (st_ff == HS_IDLE);

  always_comb begin
    enc_word = {CMD_ENCAL, cfg_ec_ff};
    enc_word[EC_CAL_EN]  = 1'b1;
    enc_word[EC_FMT_SEL] = 1'b0;
    zr_word  = {CMD_ZRCFG, cfg_zr_ff};
    case (avs_address)
      REG_TX:     rd_mux = {16'h0, tx_ff};
      REG_RX:     rd_mux = {16'h0, rx_ff};
      REG_STAT:   rd_mux = {29'h0, ok_ff, fail_ff, (st_ff != HS_IDLE)};
      REG_CFG_EC: rd_mux = {19'h0, cfg_ec_ff};
      REG_CFG_ZR: rd_mux = {19'h0, cfg_zr_ff};
      default:    rd_mux = 32'h0;
    endcase
  end

  // bus slave: one wait cycle, then accept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest_ff) begin
      avs_waitrequest_ff <= 1'b0;
      avs_readdata_ff    <= rd_mux;
    end else begin
      avs_waitrequest_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff     <= '0;
      cfg_ec_ff <= '0;
      cfg_zr_ff <= PAY_W'(ZR_STEP_DFLT);
    end else if (wr_acc) begin
      if (avs_address == REG_TX) tx_ff <= avs_writedata[FRAME_BITS-1:0];
      if (avs_address == REG_CFG_EC) cfg_ec_ff <= avs_writedata[PAY_W-1:0];
      if (avs_address == REG_CFG_ZR) cfg_zr_ff <= avs_writedata[PAY_W-1:0];
    end
  end

  // serial master, mode 0, msb first
  assign lim = (pulse_ff && !cs_ff) ? 16'(CAL_PULSE_CYC - 1) : 16'(SCK_HALF - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_ff    <= 1'b1;
      sclk_ff  <= 1'b0;
      mosi_ff  <= 1'b0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      pulse_ff <= 1'b0;
      cnt_ff   <= '0;
      ph_ff    <= '0;
      sh_ff    <= '0;
      rx_ff    <= '0;
    end else begin
      done_ff <= 1'b0;
      if (go_ff && !busy_ff) begin
        busy_ff  <= 1'b1;
        cs_ff    <= 1'b0;
        pulse_ff <= go_pulse_ff;
        sh_ff    <= go_word_ff;
        mosi_ff  <= go_word_ff[FRAME_BITS-1];
        cnt_ff   <= '0;
        ph_ff    <= '0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + 16'h1;
        if (cnt_ff == lim) begin
          cnt_ff <= '0;
          ph_ff  <= ph_ff + 6'h1;
          if (cs_ff) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end else if (!pulse_ff && ph_ff < 6'(2 * FRAME_BITS)) begin
            sclk_ff <= ~sclk_ff;
            if (!sclk_ff) begin
              rx_ff <= {rx_ff[FRAME_BITS-2:0], mi_s[0] & mi_s[1]};
            end else begin
              sh_ff   <= {sh_ff[FRAME_BITS-2:0], 1'b0};
              mosi_ff <= sh_ff[FRAME_BITS-2];
            end
          end else begin
            cs_ff <= 1'b1;
          end
        end
      end
    end
  end

  // bring-up and reset-reload sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= HS_IDLE;
      go_ff       <= 1'b0;
      go_word_ff  <= '0;
      go_pulse_ff <= 1'b0;
      rst_pin_ff  <= 1'b1;
      hold_ff     <= '0;
      tries_ff    <= '0;
      fail_ff     <= 1'b0;
      ok_ff       <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      case (st_ff)
        HS_IDLE: begin
          if (ctrl_wr && avs_writedata[CTRL_RESET]) begin
            rst_pin_ff <= 1'b0;
            hold_ff    <= '0;
            st_ff      <= HS_RESET;
          end else if (ctrl_wr && avs_writedata[CTRL_BRINGUP]) begin
            go_ff       <= 1'b1;
            go_word_ff  <= enc_word;
            go_pulse_ff <= 1'b0;
            tries_ff    <= '0;
            fail_ff     <= 1'b0;
            ok_ff       <= 1'b0;
            st_ff       <= HS_ENC;
          end else if (ctrl_wr && (avs_writedata[CTRL_FRAME] || avs_writedata[CTRL_PULSE])) begin
            go_ff       <= 1'b1;
            go_word_ff  <= tx_ff;
            go_pulse_ff <= avs_writedata[CTRL_PULSE] & ~avs_writedata[CTRL_FRAME];
            st_ff       <= HS_ONE;
          end
        end
        HS_RESET: begin
          if (hold_ff == 16'(RST_HOLD_CYC - 1)) begin
            rst_pin_ff  <= 1'b1;
            go_ff       <= 1'b1;
            go_word_ff  <= enc_word;
            go_pulse_ff <= 1'b0;
            tries_ff    <= '0;
            fail_ff     <= 1'b0;
            ok_ff       <= 1'b0;
            st_ff       <= HS_ENC;
          end else begin
            hold_ff <= hold_ff + 16'h1;
          end
        end
        HS_ENC: if (done_ff) begin
          go_ff       <= 1'b1;
          go_pulse_ff <= 1'b1;
          st_ff       <= HS_PULSE;
        end
        HS_PULSE: if (done_ff) begin
          go_ff       <= 1'b1;
          go_word_ff  <= zr_word;
          go_pulse_ff <= 1'b0;
          st_ff       <= HS_ZRC;
        end
        HS_ZRC: if (done_ff) begin
          if (!rx_ff[SO_CAL]) begin
            ok_ff <= 1'b1;
            st_ff <= HS_IDLE;
          end else if (tries_ff == 3'(MAX_TRIES - 1)) begin
            fail_ff <= 1'b1;
            st_ff   <= HS_IDLE;
          end else begin
            tries_ff    <= tries_ff + 3'h1;
            go_ff       <= 1'b1;
            go_word_ff  <= enc_word;
            go_pulse_ff <= 1'b0;
            st_ff       <= HS_ENC;
          end
        end
        HS_ONE: if (done_ff) st_ff <= HS_IDLE;
        default: st_ff <= HS_IDLE;
      endcase
    end
  end
endmodule : gfr_host

// file: src/gfr_link_if.sv
// serial link and reset pin between host and gauge device
interface gfr_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic rst_pin_n;
  modport dev  (input cs_n, input sclk, input mosi, input rst_pin_n, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, output rst_pin_n, input miso, input miso_oe);
endinterface : gfr_link_if

// file: src/gfr_pkg.sv
// shared constants for the gauge fault/reset link
package gfr_pkg;
  localparam int             CLK_NS       = 4;
  localparam int             FRAME_BITS   = 16;
  localparam int             CMD_LSB      = 13;
  localparam int             CMD_W        = 3;
  localparam logic [CMD_W-1:0] CMD_NULL   = 3'h0;
  localparam logic [CMD_W-1:0] CMD_ENCAL  = 3'h1;
  localparam logic [CMD_W-1:0] CMD_ZRCFG  = 3'h2;
  localparam int             PAY_W        = 13;
  localparam int             EC_GAUGE0    = 0;
  localparam int             EC_CAL_EN    = 3;
  localparam int             EC_FREQ_SEL  = 4;
  localparam int             EC_FMT_SEL   = 10;
  localparam int             ZR_STEP_LSB  = 0;
  localparam int             ZR_STEP_W    = 4;
  localparam int             ZR_BLANK     = 4;
  localparam int             ZR_PLO_LSB   = 5;
  localparam int             ZR_PLO_W     = 6;
  localparam int             ZR_PHI_LSB   = 11;
  localparam int             ZR_PHI_W     = 2;
  localparam logic [ZR_STEP_W-1:0] ZR_STEP_DFLT = 4'h2;
  localparam int             SO_OT0       = 0;
  localparam int             SO_UV        = 6;
  localparam int             SO_OV        = 7;
  localparam int             SO_CAL       = 8;
  localparam int             SO_ZR        = 9;
  localparam int             CAL_TICK_NS  = 1000;
  localparam int             CAL_SLOW_NS  = 1500;
  localparam int             CAL_TICK_CYC = CAL_TICK_NS / CLK_NS;
  localparam int             CAL_SLOW_CYC = CAL_SLOW_NS / CLK_NS;
  localparam int             CAL_CNT_W    = 5;
  localparam int             CAL_MIN      = 4;
  localparam int             CAL_MAX      = 15;
  localparam int             CAL_PULSE_NS = 8000;
  localparam int             CAL_PULSE_CYC = (CAL_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int             RST_HOLD_NS  = 1000;
  localparam int             RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int             ADDR_W       = 3;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 3'h0;
  localparam logic [ADDR_W-1:0] REG_TX    = 3'h1;
  localparam logic [ADDR_W-1:0] REG_RX    = 3'h2;
  localparam logic [ADDR_W-1:0] REG_STAT  = 3'h3;
  localparam logic [ADDR_W-1:0] REG_CFG_EC = 3'h4;
  localparam logic [ADDR_W-1:0] REG_CFG_ZR = 3'h5;
  localparam int             CTRL_FRAME   = 0;
  localparam int             CTRL_PULSE   = 1;
  localparam int             CTRL_RESET   = 2;
  localparam int             CTRL_BRINGUP = 3;
endpackage : gfr_pkg

// file: src/gfr_sync.sv
// two-flop synchroniser bank
module gfr_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end
endmodule : gfr_sync

// file: tb/gauge_fault_reset_control_tb.sv
// testbench for the gauge fault/reset link
module gauge_fault_reset_control_tb
  import gfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk, rst_n, avs_read, avs_write, avs_waitrequest_ff;
  logic             vdd_ok, motor_supply_below_min, motor_supply_uv, motor_supply_ov;
  logic             zr_active, zr_gauge, zr_drive_sin, cal_en_ff, freq_sel_ff, blanking_time_bit_ff;
  logic             motion_run_ff, sleep_ff, zero_return_ff;
  logic [1:0]       overtemp, coil_en_ff, overtemp_flag_ff, accumulator_preload_high_ff;
  logic [3:0]       coil_sense, full_step_time_field_ff, cal_divisor_ff;
  logic [5:0]       accumulator_preload_low_ff;
  logic [2:0]       avs_address;
  logic [31:0]      avs_writedata, avs_readdata_ff, rd;
  int               num_errors = 0;
  int               samples_checked = 0;
  int               cyc = 0;
  gfr_link_if link ();
  gfr_host #(.SCK_HALF(8), .MAX_TRIES(4)) i_gfr_host (.core_clk, .rst_n, .link, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata_ff, .avs_waitrequest_ff);
  gfr_dev i_gfr_dev (.core_clk, .rst_n, .link, .vdd_ok, .motor_supply_below_min, .motor_supply_uv,
    .motor_supply_ov, .overtemp, .coil_sense, .zr_active, .zr_gauge, .zr_drive_sin, .coil_en_ff,
    .overtemp_flag_ff, .cal_en_ff, .freq_sel_ff, .full_step_time_field_ff, .blanking_time_bit_ff,
    .accumulator_preload_high_ff, .accumulator_preload_low_ff, .cal_divisor_ff, .motion_run_ff,
    .sleep_ff, .zero_return_ff);
  gfr_link_checker i_gfr_link_checker (.core_clk, .rst_n, .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .rst_pin_n(link.rst_pin_n));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task av(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    {avs_write, avs_read} <= {w, !w};
    do @(posedge core_clk); while (avs_waitrequest_ff !== 1'b0);
    rd = avs_readdata_ff;
    {avs_write, avs_read} <= 2'h0;
  endtask : av
  task idle;
    rd = 32'h1;
    while (rd[0] !== 1'b0) av(1'b0, REG_STAT, 32'h0);
  endtask : idle
  task frame(input logic [15:0] w);
    av(1'b1, REG_TX, {16'h0, w});
    av(1'b1, REG_CTRL, 32'h1);
    idle();
    av(1'b0, REG_RX, 32'h0);
  endtask : frame
  task pulse_in(input logic [1:0] s);
    {motor_supply_uv, motor_supply_ov} <= s;
    repeat (10) @(posedge core_clk);
    {motor_supply_uv, motor_supply_ov} <= 2'h0;
  endtask : pulse_in
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, overtemp, coil_sense} = '0;
    {vdd_ok, motor_supply_below_min, motor_supply_uv, motor_supply_ov, zr_active, zr_gauge, zr_drive_sin} = 7'h40;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({coil_en_ff, motion_run_ff, sleep_ff, zero_return_ff}, 5'h04);
    chk(full_step_time_field_ff, ZR_STEP_DFLT);
    chk({cal_en_ff, freq_sel_ff, blanking_time_bit_ff, accumulator_preload_low_ff, cal_divisor_ff}, 0);
    frame({CMD_NULL, 13'h0});
    chk({rd[SO_UV], rd[SO_OV]}, 2'h2);
    pulse_in(2'h3);
    frame({CMD_NULL, 13'h0});
    chk({rd[SO_UV], rd[SO_OV]}, 2'h1);
    frame({CMD_NULL, 13'h0});
    chk({rd[SO_OV], rd[5:2]}, 0);
    frame({CMD_ENCAL, 13'h000b});
    chk({coil_en_ff, cal_en_ff}, 3'h7);
    pulse_in(2'h2);
    av(1'b1, REG_CTRL, 32'h2);
    idle();
    chk(cal_divisor_ff, 4'h8);
    frame({CMD_NULL, 13'h0});
    chk({rd[SO_CAL], rd[SO_UV]}, 2'h1);
    overtemp <= 2'h1;
    repeat (10) @(posedge core_clk);
    chk({coil_en_ff, overtemp_flag_ff}, 4'h9);
    overtemp <= 2'h0;
    frame({CMD_NULL, 13'h0});
    chk({rd[1:0], overtemp_flag_ff}, 4'h5);
    frame({CMD_ENCAL, 13'h000b});
    chk({coil_en_ff, overtemp_flag_ff}, 4'hc);
    frame({CMD_ZRCFG, 13'h1d35});
    chk({accumulator_preload_high_ff, accumulator_preload_low_ff, blanking_time_bit_ff,
      full_step_time_field_ff}, 13'h1d35);
    for (int i = 0; i < 4; i++) begin
      {zr_active, zr_gauge, zr_drive_sin} <= i[1] ? 3'h6 : 3'h5;
      coil_sense <= i[0] ? 4'h6 : 4'h9;
      repeat (8) @(posedge core_clk);
      chk(zero_return_ff, !i[0]);
    end
    zr_active <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(zero_return_ff, 1'b0);
    for (int i = 0; i < 2; i++) begin
      {vdd_ok, motor_supply_below_min} <= i[0] ? 2'h3 : 2'h0;
      repeat (10) @(posedge core_clk);
      chk({coil_en_ff, motion_run_ff}, 3'h0);
      {vdd_ok, motor_supply_below_min} <= 2'h2;
      repeat (10) @(posedge core_clk);
      chk({full_step_time_field_ff, cal_en_ff, motion_run_ff}, {ZR_STEP_DFLT, 2'h1});
    end
    av(1'b1, REG_CFG_EC, 32'h13);
    av(1'b1, REG_CFG_ZR, 32'h7);
    av(1'b1, REG_CTRL, 32'h4);
    repeat (20) @(posedge core_clk);
    chk({sleep_ff, coil_en_ff}, 3'h4);
    idle();
    chk(rd[2:1], 2'h2);
    chk({coil_en_ff, freq_sel_ff, full_step_time_field_ff}, 7'h77);
    av(1'b1, 3'h7, 32'hffff);
    av(1'b0, 3'h7, 32'h0);
    chk(rd, 0);
    stop_test();
  end
endmodule : gauge_fault_reset_control_tb

// file: tb/gfr_link_checker.sv
// link protocol checker for the gauge fault/reset link
module gfr_link_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic rst_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_sclk_in_frame: assert property ($rose(sclk) |-> !cs_n)
    else $error("sclk rose outside a frame");
  a_sclk_half_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase wrong length");
  a_mosi_held: assert property (sclk |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  a_oe_idle_off: assert property (cs_n [*5] |-> !miso_oe)
    else $error("miso driven outside frame");
  a_oe_frame_on: assert property ($fell(cs_n) |-> ##[1:10] miso_oe)
    else $error("miso not driven in frame");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
    else $error("miso not released after frame");
  a_rst_pin_hold: assert property ($fell(rst_pin_n) |-> !rst_pin_n [*8])
    else $error("reset pin pulse too short");
  a_rst_link_quiet: assert property (!rst_pin_n |-> cs_n && !sclk)
    else $error("link active during reset pin");
  c_frame: cover property ($rose(cs_n));
  c_rst_pin: cover property ($rose(rst_pin_n));
  c_miso_one: cover property (miso_oe && miso);
endmodule : gfr_link_checker
